/* File: hdl/ssq_pkg.sv */
package ssq_pkg;
    // Register byte offsets
    localparam logic [5:0] OFS_STB    = 6'h00;
    localparam logic [5:0] OFS_SRE    = 6'h04;
    localparam logic [5:0] OFS_OUTQ   = 6'h08;
    localparam logic [5:0] OFS_ERRQ   = 6'h0c;
    localparam logic [5:0] OFS_CTRL   = 6'h10;
    localparam logic [5:0] OFS_FRANGE = 6'h14;
    localparam logic [5:0] OFS_FCMD   = 6'h18;
    localparam logic [5:0] OFS_PROBE  = 6'h1c;
    localparam logic [5:0] OFS_LEVEL  = 6'h20;

    // Status byte bit positions
    localparam int unsigned STB_ERR_BIT = 2;
    localparam int unsigned STB_MSG_BIT = 4;
    localparam int unsigned STB_RQS_BIT = 6;
    localparam logic [7:0]  SRE_RESET   = 8'h00;

    // Control and filter command fields
    localparam int unsigned CTRL_CLS_BIT    = 0;
    localparam int unsigned CTRL_QCLR_BIT   = 1;
    localparam int unsigned FCMD_ALLOW_BIT  = 0;
    localparam int unsigned FCMD_WIPE_BIT   = 1;
    localparam int unsigned FCMD_APPEND_BIT = 2;

    // Message codes
    localparam logic signed [15:0] CODE_NO_ERROR = 16'sh0000;
    localparam logic signed [15:0] CODE_OVERFLOW = 16'sh015e;
    localparam logic signed [15:0] CODE_MIN      = 16'sh8000;
    localparam logic signed [15:0] CODE_MAX      = 16'sh7fff;
    localparam logic signed [15:0] STATUS_LO_DEF = 16'sh0100;
    localparam logic signed [15:0] STATUS_HI_DEF = 16'sh01ff;

    // Depths and widths
    localparam int unsigned ERRQ_DEPTH = 10;
    localparam int unsigned OUTQ_DEPTH = 16;
    localparam int unsigned OUTQ_W     = 8;
    localparam int unsigned FLT_N      = 8;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // One filter entry: code range, either order, and its verdict
    typedef struct packed {
        logic               allow;
        logic signed [15:0] hi;
        logic signed [15:0] lo;
    } ssq_flt_s;
endpackage

/* File: hdl/ssq_status_queues.sv */
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
module ssq_status_queues #(
    parameter int unsigned        OQ_DEPTH  = ssq_pkg::OUTQ_DEPTH,
    parameter int unsigned        OQ_W      = ssq_pkg::OUTQ_W,
    parameter int unsigned        EQ_DEPTH  = ssq_pkg::ERRQ_DEPTH,
    parameter int unsigned        FLT_N     = ssq_pkg::FLT_N,
    parameter logic signed [15:0] STATUS_LO = ssq_pkg::STATUS_LO_DEF,
    parameter logic signed [15:0] STATUS_HI = ssq_pkg::STATUS_HI_DEF
) (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [5:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output wire logic               s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output wire logic               s_axi_wready,
    output logic      [1:0]         s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [5:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output wire logic               s_axi_arready,
    output logic      [31:0]        s_axi_rdata,
    output logic      [1:0]         s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire logic               resp_valid,
    input  wire logic [OQ_W-1:0]    resp_data,
    output wire logic               resp_ready,
    input  wire logic               err_valid,
    input  wire logic signed [15:0] err_code,
    output logic                    message_available_flag,
    output logic                    error_available_flag,
    output wire logic               service_request
);
    localparam int OCW = $clog2(OQ_DEPTH + 1);
    localparam int ECW = $clog2(EQ_DEPTH + 1);
    localparam int FCW = $clog2(FLT_N + 1);

    // Counts are reported in one byte each
    if (OQ_DEPTH < 2 || OCW > 8 || ECW > 8 || EQ_DEPTH < 2 || OQ_W > 32 || OQ_W < 1 || FLT_N < 2) begin : g_chk
        $error("ssq_status_queues: unsupported parameter set");
    end

    // Mapped registers are aligned words up to the level register
    function automatic logic is_mapped(input logic [5:0] a);
        is_mapped = (a[1:0] == 2'h0) && (a <= ssq_pkg::OFS_LEVEL);
    endfunction

    // Byte-lane merge for staged registers
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        lane_merge = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                lane_merge[8*b +: 8] = nw[8*b +: 8];
            end
        end
    endfunction

    // Last matching entry decides; no match means disabled
    function automatic logic code_enabled(input ssq_pkg::ssq_flt_s [FLT_N-1:0] tbl, input logic [FCW-1:0] used,
                                          input logic signed [15:0] code);
        logic signed [15:0] lo;
        logic signed [15:0] hi;
        code_enabled = 1'b0;
        for (int i = 0; i < FLT_N; i++) begin
            lo = tbl[i].lo;
            hi = tbl[i].hi;
            if (FCW'(i) < used && ((code >= lo && code <= hi) || (code >= hi && code <= lo))) begin
                code_enabled = tbl[i].allow;
            end
        end
    endfunction

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // AXI write path: address and data captured in either order
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [5:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    wire         aw_take = s_axi_awvalid && s_axi_awready;
    wire         w_take  = s_axi_wvalid && s_axi_wready;
    wire         wr_fire = (aw_held_reg || aw_take) && (w_held_reg || w_take);
    wire [5:0]   wa      = aw_held_reg ? awaddr_reg : s_axi_awaddr;
    wire [31:0]  wd      = w_held_reg ? wdata_reg : s_axi_wdata;
    wire [3:0]   ws      = w_held_reg ? wstrb_reg : s_axi_wstrb;
    wire         wr_ok   = wr_fire && is_mapped(wa);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            awaddr_reg   <= 6'h00;
            wdata_reg    <= 32'h0000_0000;
            wstrb_reg    <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= ssq_pkg::RESP_OKAY;
        end else begin
            if (aw_take) awaddr_reg <= s_axi_awaddr;
            if (w_take) wdata_reg <= s_axi_wdata;
            if (w_take) wstrb_reg <= s_axi_wstrb;
            aw_held_reg <= wr_fire ? 1'b0 : (aw_held_reg || aw_take);
            w_held_reg  <= wr_fire ? 1'b0 : (w_held_reg || w_take);
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? ssq_pkg::RESP_OKAY : ssq_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Write strobes; command bits live in byte 0
    wire wr_sre    = wr_ok && wa == ssq_pkg::OFS_SRE && ws[0];
    wire wr_ctrl   = wr_ok && wa == ssq_pkg::OFS_CTRL && ws[0];
    wire wr_frange = wr_ok && wa == ssq_pkg::OFS_FRANGE;
    wire wr_fcmd   = wr_ok && wa == ssq_pkg::OFS_FCMD && ws[0];
    wire wr_probe  = wr_ok && wa == ssq_pkg::OFS_PROBE;

    // Read path: one read at a time, pops happen at the address handshake
    assign s_axi_arready = !s_axi_rvalid;
    wire rd_fire = s_axi_arvalid && s_axi_arready;
    wire rd_ok   = rd_fire && is_mapped(s_axi_araddr);

    // Output queue: shift storage, head at index 0
    logic [OQ_W-1:0] oq_mem_reg [OQ_DEPTH];
    logic [OCW-1:0]  oq_cnt_reg;
    wire             oq_empty = oq_cnt_reg == '0;
    assign resp_ready = oq_cnt_reg != OCW'(OQ_DEPTH);
    wire             oq_push  = resp_valid && resp_ready;
    wire             oq_pop   = rd_ok && s_axi_araddr == ssq_pkg::OFS_OUTQ && !oq_empty;
    wire [OCW-1:0]   oq_widx  = oq_cnt_reg - OCW'(oq_pop);
    wire [OCW-1:0]   oq_cnt_next = oq_widx + OCW'(oq_push);

    for (genvar gi = 0; gi < OQ_DEPTH; gi++) begin : g_oq
        // Popping shifts toward the head; a push lands behind the last survivor
        always_ff @(posedge aclk) begin
            if (oq_push && oq_widx == OCW'(gi)) begin
                oq_mem_reg[gi] <= resp_data;
            end else if (oq_pop) begin
                oq_mem_reg[gi] <= oq_mem_reg[(gi + 1) % OQ_DEPTH];
            end
        end
    end

    // Filter table and staged range
    ssq_pkg::ssq_flt_s [FLT_N-1:0] flt_tbl_reg;
    logic [FCW-1:0]                flt_used_reg;
    logic                          flt_full_reg;
    logic [31:0]                   frange_reg;
    logic signed [15:0]            probe_reg;
    wire                           f_wipe   = wr_fcmd && wd[ssq_pkg::FCMD_WIPE_BIT];
    wire                           f_append = wr_fcmd && wd[ssq_pkg::FCMD_APPEND_BIT];
    wire [FCW-1:0]                 f_base   = f_wipe ? '0 : flt_used_reg;
    wire                           f_room   = f_base != FCW'(FLT_N);
    wire ssq_pkg::ssq_flt_s        f_entry  = '{allow: wd[ssq_pkg::FCMD_ALLOW_BIT],
                                               hi: frange_reg[31:16], lo: frange_reg[15:0]};

    // Enable = wipe then allow entries; disable = deny entries appended
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flt_tbl_reg    <= '0;
            flt_tbl_reg[0] <= '{allow: 1'b1, hi: ssq_pkg::CODE_MAX, lo: ssq_pkg::CODE_MIN};
            flt_tbl_reg[1] <= '{allow: 1'b0, hi: STATUS_HI, lo: STATUS_LO};
            flt_used_reg   <= FCW'(2);
            flt_full_reg   <= 1'b0;
            frange_reg     <= 32'h0000_0000;
            probe_reg      <= 16'sh0000;
        end else begin
            if (wr_frange) frange_reg <= lane_merge(frange_reg, wd, ws);
            if (wr_probe) probe_reg <= 16'(lane_merge({16'h0000, probe_reg}, wd, ws));
            if (f_append && f_room) begin
                flt_tbl_reg[f_base] <= f_entry;
                flt_used_reg        <= f_base + FCW'(1);
            end else if (f_wipe) begin
                flt_used_reg <= '0;
            end
            // Table overflow is sticky until the next wipe; a rejected append wins
            if (f_append && !f_room) flt_full_reg <= 1'b1;
            else if (f_wipe) flt_full_reg <= 1'b0;
        end
    end

    // Error queue with filter and overflow marker
    logic signed [15:0] eq_mem_reg [EQ_DEPTH];
    logic [ECW-1:0]     eq_cnt_reg;
    wire                eq_clear = wr_ctrl && (wd[ssq_pkg::CTRL_CLS_BIT] || wd[ssq_pkg::CTRL_QCLR_BIT]);
    wire                eq_pop   = rd_ok && s_axi_araddr == ssq_pkg::OFS_ERRQ && eq_cnt_reg != '0 && !eq_clear;
    wire [ECW-1:0]      eq_base  = eq_clear ? '0 : eq_cnt_reg - ECW'(eq_pop);
    wire                eq_admit = err_valid && code_enabled(flt_tbl_reg, flt_used_reg, err_code);
    wire                eq_push  = eq_admit && eq_base != ECW'(EQ_DEPTH);
    wire                eq_last  = eq_base == ECW'(EQ_DEPTH - 1);
    wire signed [15:0]  eq_wval  = eq_last ? ssq_pkg::CODE_OVERFLOW : err_code;
    wire [ECW-1:0]      eq_cnt_next = eq_base + ECW'(eq_push);

    for (genvar gj = 0; gj < EQ_DEPTH; gj++) begin : g_eq
        // Oldest entry stays at index 0
        always_ff @(posedge aclk) begin
            if (eq_push && eq_base == ECW'(gj)) begin
                eq_mem_reg[gj] <= eq_wval;
            end else if (eq_pop) begin
                eq_mem_reg[gj] <= eq_mem_reg[(gj + 1) % EQ_DEPTH];
            end
        end
    end

    // Counts and summary flags; preset is not decoded, so queue and filter ride through it
    logic [7:0] sre_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oq_cnt_reg             <= '0;
            eq_cnt_reg             <= '0;
            message_available_flag <= 1'b0;
            error_available_flag   <= 1'b0;
            sre_reg                <= ssq_pkg::SRE_RESET;
        end else begin
            oq_cnt_reg             <= oq_cnt_next;
            eq_cnt_reg             <= eq_cnt_next;
            message_available_flag <= oq_cnt_next != '0;
            error_available_flag   <= eq_cnt_next != '0;
            if (wr_sre) sre_reg <= wd[7:0];
        end
    end

    // Status byte and service request
    wire [7:0] stb_core = (8'(message_available_flag) << ssq_pkg::STB_MSG_BIT)
                        | (8'(error_available_flag) << ssq_pkg::STB_ERR_BIT);
    assign service_request = |(stb_core & sre_reg);
    wire [7:0] stb_full = stb_core | (8'(service_request) << ssq_pkg::STB_RQS_BIT);

    // Read data selection; empty queues answer zero
    wire [31:0] rd_outq  = oq_empty ? 32'h0000_0000 : 32'(oq_mem_reg[0]);
    wire [31:0] rd_errq  = (eq_cnt_reg == '0) ? 32'(ssq_pkg::CODE_NO_ERROR) : 32'(signed'(eq_mem_reg[0]));
    wire        probe_en = code_enabled(flt_tbl_reg, flt_used_reg, probe_reg);
    wire [31:0] rd_probe = {probe_reg, 14'h0000, flt_full_reg, probe_en};
    wire [31:0] rd_level = {16'h0000, 8'(eq_cnt_reg), 8'(oq_cnt_reg)};
    wire [31:0] rd_fcmd  = {28'h000_0000, 4'(flt_used_reg)};
    wire [5:0]  ra       = s_axi_araddr;
    wire [31:0] rd_value = (ra == ssq_pkg::OFS_STB)    ? {24'h00_0000, stb_full} :
                           (ra == ssq_pkg::OFS_SRE)    ? {24'h00_0000, sre_reg} :
                           (ra == ssq_pkg::OFS_OUTQ)   ? rd_outq :
                           (ra == ssq_pkg::OFS_ERRQ)   ? rd_errq :
                           (ra == ssq_pkg::OFS_FRANGE) ? frange_reg :
                           (ra == ssq_pkg::OFS_FCMD)   ? rd_fcmd :
                           (ra == ssq_pkg::OFS_PROBE)  ? rd_probe :
                           (ra == ssq_pkg::OFS_LEVEL)  ? rd_level : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= ssq_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_value;
            s_axi_rresp  <= rd_ok ? ssq_pkg::RESP_OKAY : ssq_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Checks
    chk_resp_queued: assert property (oq_push && !oq_pop |=> oq_cnt_reg == $past(oq_cnt_reg) + OCW'(1))
        else $error("response not queued");
    chk_push_sets_msg: assert property (oq_push |=> message_available_flag)
        else $error("message flag not set after push");
    chk_msg_empty: assert property (oq_pop && oq_cnt_reg == OCW'(1) && !oq_push |=> !message_available_flag)
        else $error("message flag stuck after last pop");
    chk_srq_raise: assert property (message_available_flag && sre_reg[ssq_pkg::STB_MSG_BIT] |-> service_request)
        else $error("service request missing");
    chk_eav_track: assert property (error_available_flag == (eq_cnt_reg != '0))
        else $error("error flag disagrees with queue");
    chk_eq_capacity: assert property (eq_cnt_reg <= ECW'(EQ_DEPTH))
        else $error("error queue over capacity");
    chk_oldest_first: assert property (eq_pop && !eq_push |=> s_axi_rdata == 32'(signed'($past(eq_mem_reg[0]))))
        else $error("error read not oldest");
    chk_overflow_mark: assert property (eq_cnt_reg == ECW'(EQ_DEPTH) |-> eq_mem_reg[EQ_DEPTH-1] == ssq_pkg::CODE_OVERFLOW)
        else $error("overflow marker missing");
    chk_empty_errread: assert property (rd_fire && ra == ssq_pkg::OFS_ERRQ && eq_cnt_reg == '0 |=> s_axi_rdata == 32'h0)
        else $error("empty error read not zero");
    chk_filter_gate: assert property (err_valid && !eq_admit && !eq_pop && !eq_clear |=> $stable(eq_cnt_reg))
        else $error("disabled code was queued");
    chk_clear_empty: assert property (eq_clear && !eq_push |=> eq_cnt_reg == '0 ##1 1'b1)
        else $error("error queue not cleared");
    chk_full_drops: assert property (eq_cnt_reg == ECW'(EQ_DEPTH) && !eq_pop && !eq_clear |=> eq_cnt_reg == ECW'(EQ_DEPTH))
        else $error("full error queue changed");

    cov_overflow: cover property (eq_cnt_reg == ECW'(EQ_DEPTH));
    cov_srq: cover property ($rose(service_request));
    cov_empty_read: cover property (rd_fire && ra == ssq_pkg::OFS_ERRQ && eq_cnt_reg == '0);
    cov_wipe_only: cover property (f_wipe && !f_append);
endmodule

/* File: testbench/ssq_host_model.sv */
`timescale 1ns/100ps
// Remote controller seen as a register bus master
module ssq_host_model (
    input  wire logic        aclk,
    output logic      [5:0]  awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic      [31:0] wdata,
    output logic      [3:0]  wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic        bvalid,
    output logic             bready,
    output logic      [5:0]  araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic        rvalid,
    output logic             rready
);
    // Idle bus; response readies held high so no answer is ever missed
    initial begin
        {awaddr, awvalid, wdata, wvalid, araddr, arvalid} = '0;
        wstrb  = 4'hf;
        bready = 1'b1;
        rready = 1'b1;
    end

    // Address and data offered together, each released once taken
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr  <= ~a;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata  <= ~d;
            end
            if (bvalid) break;
        end
    endtask

    // Query first, then pull the answer out
    task automatic rd(input logic [5:0] a, output logic [31:0] d);
        araddr  <= a;
        arvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr  <= ~a;
            end
            if (rvalid) begin
                d = rdata;
                break;
            end
        end
    endtask
endmodule

/* File: testbench/ssq_status_queues_bench.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module ssq_status_queues_bench;
    logic               aclk = 1'b0;
    logic               aresetn = 1'b0;
    logic               resp_valid = 1'b0;
    logic        [7:0]  resp_data = 8'h00;
    logic               err_valid = 1'b0;
    logic signed [15:0] err_code = 16'sh0000;
    logic        [5:0]  awaddr, araddr;
    logic        [31:0] wdata, rdata, d;
    logic        [3:0]  wstrb;
    logic        [1:0]  bresp, rresp;
    logic               awvalid, awready, wvalid, wready, bvalid, bready;
    logic               arvalid, arready, rvalid, rready, resp_ready, msg_flag, err_flag, srq;
    int                 errors = 0;
    int                 checks = 0;
    int                 cyc = 0;

    always #20 aclk = ~aclk;

    ssq_host_model host_u (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready));

    ssq_status_queues dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .resp_valid(resp_valid),
        .resp_data(resp_data), .resp_ready(resp_ready), .err_valid(err_valid), .err_code(err_code),
        .message_available_flag(msg_flag), .error_available_flag(err_flag), .service_request(srq));

    task automatic close_out;
        if (errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Hang guard well above the hundred-odd cycles the run needs
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 6000) begin
            errors++;
            close_out();
        end
    end

    task automatic rc(input logic [5:0] a, input logic [31:0] e);
        host_u.rd(a, d);
        `CHK(d, e)
    endtask

    // One query answer into the output queue; a spare edge keeps valid strokes apart
    task automatic push(input logic [7:0] v);
        @(posedge aclk);
        resp_valid <= 1'b1;
        resp_data  <= v;
        do @(posedge aclk); while (!resp_ready);
        resp_valid <= 1'b0;
        resp_data  <= ~v;
    endtask

    // A burst of n events with rising codes, one per cycle
    task automatic ev(input logic [15:0] c, input int n);
        @(posedge aclk);
        for (int i = 0; i < n; i++) begin
            err_valid <= 1'b1;
            err_code  <= c + i[15:0];
            @(posedge aclk);
        end
        err_valid <= 1'b0;
        err_code  <= ~c;
    endtask

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // Power-up state
        rc(ssq_pkg::OFS_STB, 32'h0);
        rc(ssq_pkg::OFS_FCMD, 32'h2);
        rc(ssq_pkg::OFS_ERRQ, 32'h0);
        // Output queue, summary bit and service request
        push(8'ha5);
        push(8'h3c);
        `CHK(msg_flag, 1'b1)
        host_u.wr(ssq_pkg::OFS_SRE, 32'h10);
        host_u.rd(ssq_pkg::OFS_STB, d);
        `CHK(d[4], 1'b1)
        `CHK(srq, 1'b1)
        rc(ssq_pkg::OFS_OUTQ, 32'ha5);
        `CHK(msg_flag, 1'b1)
        rc(ssq_pkg::OFS_OUTQ, 32'h3c);
        `CHK({msg_flag, srq}, 2'b00)
        // Error code passes, status code held back by default
        ev(16'hfffb, 1);
        ev(16'h0150, 1);
        `CHK(err_flag, 1'b1)
        rc(ssq_pkg::OFS_LEVEL, 32'h0100);
        rc(ssq_pkg::OFS_ERRQ, 32'hfffffffb);
        `CHK(err_flag, 1'b0)
        // Overfill: nine codes, then the overflow marker, rest dropped
        ev(16'h0001, 12);
        rc(ssq_pkg::OFS_LEVEL, 32'h0a00);
        for (int i = 1; i <= 9; i++) begin
            rc(ssq_pkg::OFS_ERRQ, i);
        end
        rc(ssq_pkg::OFS_ERRQ, 32'h15e);
        `CHK(err_flag, 1'b0)
        // Both clear controls empty the queue, filter kept
        ev(16'hfff9, 2);
        host_u.wr(ssq_pkg::OFS_CTRL, 32'h2);
        rc(ssq_pkg::OFS_LEVEL, 32'h0);
        ev(16'hfff9, 1);
        host_u.wr(ssq_pkg::OFS_CTRL, 32'h1);
        rc(ssq_pkg::OFS_LEVEL, 32'h0);
        host_u.wr(ssq_pkg::OFS_PROBE, 32'h0150);
        rc(ssq_pkg::OFS_PROBE, 32'h01500000);
        host_u.wr(ssq_pkg::OFS_PROBE, 32'hfff9);
        rc(ssq_pkg::OFS_PROBE, 32'hfff90001);
        // Enable a range only, then carve one code out of it
        host_u.wr(ssq_pkg::OFS_FRANGE, 32'hff22ff92);
        host_u.wr(ssq_pkg::OFS_FCMD, 32'h7);
        rc(ssq_pkg::OFS_FCMD, 32'h1);
        host_u.wr(ssq_pkg::OFS_PROBE, 32'hff22);
        rc(ssq_pkg::OFS_PROBE, 32'hff220001);
        host_u.wr(ssq_pkg::OFS_PROBE, 32'hff9c);
        rc(ssq_pkg::OFS_PROBE, 32'hff9c0000);
        host_u.wr(ssq_pkg::OFS_FRANGE, 32'hff6aff6a);
        host_u.wr(ssq_pkg::OFS_FCMD, 32'h4);
        host_u.wr(ssq_pkg::OFS_PROBE, 32'hff6a);
        rc(ssq_pkg::OFS_PROBE, 32'hff6a0000);
        ev(16'hff6a, 1);
        ev(16'hff88, 1);
        rc(ssq_pkg::OFS_LEVEL, 32'h0100);
        rc(ssq_pkg::OFS_ERRQ, 32'hffffff88);
        // Empty enable list shuts everything out
        host_u.wr(ssq_pkg::OFS_FCMD, 32'h2);
        rc(ssq_pkg::OFS_FCMD, 32'h0);
        ev(16'hff88, 1);
        rc(ssq_pkg::OFS_LEVEL, 32'h0);
        `CHK(err_flag, 1'b0)
        close_out();
    end
endmodule
